// file: spu_pkg.sv
// Constants, register map and types of the four-mode serial port
package spu_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0]  SPU_IDX_CONFIG = 10'h098;
    localparam logic [9:0]  SPU_IDX_DATA   = 10'h099;
    localparam logic [9:0]  SPU_IDX_AUX    = 10'h09A;
    localparam logic [7:0]  SPU_CONFIG_RST = 8'h00;
    localparam logic [7:0]  SPU_DATA_RST   = 8'h00;
    localparam logic [7:0]  SPU_AUX_RST    = 8'h00;
    // Config field positions
    localparam int SPU_B_MODE_HI  = 7;
    localparam int SPU_B_MODE_LO  = 6;
    localparam int SPU_B_MP_EN    = 5;
    localparam int SPU_B_RX_EN    = 4;
    localparam int SPU_B_TX_NINTH = 3;
    localparam int SPU_B_RX_NINTH = 2;
    localparam int SPU_B_TX_FLAG  = 1;
    localparam int SPU_B_RX_FLAG  = 0;
    // Aux field positions
    localparam int SPU_B_DOUBLER  = 0;
    localparam int SPU_B_TX_T2    = 1;
    localparam int SPU_B_RX_T2    = 2;
    localparam int SPU_B_IRQ_EN   = 3;
    localparam int SPU_B_IRQ_PRI  = 4;
    localparam int SPU_B_REDUCED  = 5;
    // Timing in core clock cycles, frame lengths in bits and bus response codes
    localparam logic [15:0] SPU_SHIFT_DIV  = 16'h000C;
    localparam logic [15:0] SPU_FIX_DIV    = 16'h0040;
    localparam logic [15:0] SPU_FIX_DIV2   = 16'h0020;
    localparam logic [3:0]  SPU_LEN_SHIFT  = 4'h8;
    localparam logic [3:0]  SPU_LEN_8BIT   = 4'hA;
    localparam logic [3:0]  SPU_LEN_9BIT   = 4'hB;
    localparam logic [1:0]  SPU_RESP_OKAY  = 2'b00;
    localparam logic [1:0]  SPU_RESP_SLV   = 2'b10;
    typedef enum logic [1:0] {
        SPU_MODE_SHIFT,
        SPU_MODE_8BIT,
        SPU_MODE_9FIX,
        SPU_MODE_9VAR
    } spu_mode_t;
endpackage : spu_pkg

// file: spu_serial_port.sv
// Four-mode serial port with AXI4-Lite register access
`timescale 1ns/1ps
module spu_serial_port
    import spu_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    // Timer overflow pulses
    input  wire logic              timer1_ovf_in,
    input  wire logic              timer2_ovf_in,
    // Serial pins
    output logic                   serial_out_pin_out,
    input  wire logic              serial_in_pin_in,
    output logic                   serial_in_pin_out,
    output logic                   serial_in_pin_oe_out,
    // System
    output logic                   serial_irq_out,
    output logic                   irq_priority_out,
    output logic                   reduced_speed_mode_out,
    output logic                   wake_out
);
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    typedef enum logic [1:0] {SPU_TX_IDLE, SPU_TX_SEND, SPU_TX_M0RX} spu_tx_t;
    typedef enum logic [0:0] {SPU_RX_IDLE, SPU_RX_BUSY} spu_rx_t;

    logic [7:0]        config_q;
    logic [7:0]        aux_q;
    logic [7:0]        rx_buffer;
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [7:0]        w_data;
    logic              w_en;
    logic              w_held;
    logic              pin_meta;
    logic              pin_sync;
    logic              pin_prev;
    logic [15:0]       t1_cnt;
    logic [15:0]       t1_period;
    logic [15:0]       t2_cnt;
    logic [15:0]       t2_period;
    spu_tx_t           tx_state;
    logic [10:0]       tx_shift;
    logic [3:0]        tx_bits;
    logic [15:0]       tx_cnt;
    logic [7:0]        m0_shift;
    spu_rx_t           rx_state;
    logic [15:0]       rx_cnt;
    logic [3:0]        rx_idx;
    logic [8:0]        rx_shift;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    spu_mode_t mode;
    wire [9:0] aw_idx      = aw_addr[11:2];
    wire [9:0] ar_idx      = s_axi_araddr_in[11:2];
    wire       aw_high_ok  = (ADDR_W == 12) ? 1'b1 : (aw_addr >> 12) == '0;
    wire       ar_high_ok  = (ADDR_W == 12) ? 1'b1 : (s_axi_araddr_in >> 12) == '0;
    wire       wr_fire     = aw_held && w_held && !s_axi_bvalid_out;
    wire       wr_hit_cfg  = aw_high_ok && aw_idx == SPU_IDX_CONFIG;
    wire       wr_hit_dat  = aw_high_ok && aw_idx == SPU_IDX_DATA;
    wire       wr_hit_aux  = aw_high_ok && aw_idx == SPU_IDX_AUX;
    wire       wr_cfg      = wr_fire && wr_hit_cfg && w_en;
    wire       wr_dat      = wr_fire && wr_hit_dat && w_en;
    wire       wr_aux      = wr_fire && wr_hit_aux && w_en;
    wire       wr_mapped   = wr_hit_cfg || wr_hit_dat || wr_hit_aux;
    wire       rd_fire     = s_axi_arvalid_in && s_axi_arready_out;
    wire       rd_hit_cfg  = ar_high_ok && ar_idx == SPU_IDX_CONFIG;
    wire       rd_hit_dat  = ar_high_ok && ar_idx == SPU_IDX_DATA;
    wire       rd_hit_aux  = ar_high_ok && ar_idx == SPU_IDX_AUX;
    wire       rd_mapped   = rd_hit_cfg || rd_hit_dat || rd_hit_aux;
    // Data reads return the receive holding register only
    wire [7:0] rd_byte     = rd_hit_cfg ? config_q :
                             rd_hit_dat ? rx_buffer :
                             rd_hit_aux ? aux_q : 8'h00;

    assign s_axi_awready_out = !aw_held;
    assign s_axi_wready_out  = !w_held;
    assign s_axi_arready_out = !s_axi_rvalid_out;

    ////////////////////////////////////////////////////////////////////////
    // Field views
    assign mode = spu_mode_t'(config_q[SPU_B_MODE_HI:SPU_B_MODE_LO]);
    wire mp_en     = config_q[SPU_B_MP_EN];
    wire rx_en     = config_q[SPU_B_RX_EN];
    wire tx_ninth  = config_q[SPU_B_TX_NINTH];
    wire receive_complete_flag       = config_q[SPU_B_RX_FLAG];
    wire transmit_complete_flag       = config_q[SPU_B_TX_FLAG];
    wire doubler   = aux_q[SPU_B_DOUBLER];
    wire nine_bit  = mode == SPU_MODE_9FIX || mode == SPU_MODE_9VAR;

    ////////////////////////////////////////////////////////////////////////
    // Bit periods
    wire [15:0] t1_rate   = doubler ? t1_period : {t1_period[14:0], 1'b0};
    wire [15:0] fix_rate  = doubler ? SPU_FIX_DIV2 : SPU_FIX_DIV;
    wire [15:0] tx_var    = aux_q[SPU_B_TX_T2] ? t2_period : t1_rate;
    wire [15:0] rx_var    = aux_q[SPU_B_RX_T2] ? t2_period : t1_rate;
    wire [15:0] tx_period = mode == SPU_MODE_SHIFT ? SPU_SHIFT_DIV :
                            mode == SPU_MODE_9FIX ? fix_rate : tx_var;
    wire [15:0] rx_period = mode == SPU_MODE_9FIX ? fix_rate : rx_var;
    wire [15:0] tx_half   = {1'b0, tx_period[15:1]};
    wire [15:0] rx_half   = {1'b0, rx_period[15:1]};

    ////////////////////////////////////////////////////////////////////////
    // Transmit and shift-register sequencer
    wire        tx_idle   = tx_state == SPU_TX_IDLE;
    wire        tx_start  = wr_dat && tx_idle;
    wire        m0_start  = !tx_start && tx_idle && mode == SPU_MODE_SHIFT
                            && rx_en && !receive_complete_flag;
    wire        tx_tick   = !tx_idle && (tx_cnt >= tx_period - 16'h0001);
    wire        tx_last   = tx_tick && tx_bits == 4'h1;
    wire        tx_done   = tx_last && tx_state == SPU_TX_SEND;
    wire        m0_sample = tx_state == SPU_TX_M0RX && tx_cnt == tx_half;
    wire        m0_done   = tx_last && tx_state == SPU_TX_M0RX;
    wire [10:0] tx_frame  = mode == SPU_MODE_SHIFT ? {3'b111, w_data} :
                            nine_bit ? {1'b1, tx_ninth, w_data, 1'b0} :
                            {2'b11, w_data, 1'b0};
    wire [3:0]  tx_len    = mode == SPU_MODE_SHIFT ? SPU_LEN_SHIFT :
                            nine_bit ? SPU_LEN_9BIT : SPU_LEN_8BIT;
    wire        m0_clk    = tx_idle || tx_cnt < tx_half;

    assign serial_out_pin_out   = mode == SPU_MODE_SHIFT ? m0_clk :
                                  (tx_state == SPU_TX_SEND ? tx_shift[0] : 1'b1);
    assign serial_in_pin_out    = tx_shift[0];
    assign serial_in_pin_oe_out = mode == SPU_MODE_SHIFT && tx_state == SPU_TX_SEND;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tx_state <= SPU_TX_IDLE;
            tx_shift <= 11'h7FF;
            tx_bits  <= 4'h0;
            tx_cnt   <= 16'h0000;
            m0_shift <= 8'h00;
        end else begin
            unique case (tx_state)
                SPU_TX_IDLE: begin
                    tx_cnt  <= 16'h0000;
                    tx_bits <= tx_len;
                    if (tx_start) begin
                        tx_shift <= tx_frame;
                        tx_state <= SPU_TX_SEND;
                    end else if (m0_start) begin
                        tx_state <= SPU_TX_M0RX;
                    end
                end
                default: begin
                    tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
                    if (m0_sample) begin
                        m0_shift <= {pin_sync, m0_shift[7:1]};
                    end
                    if (tx_tick) begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        tx_bits  <= tx_bits - 4'h1;
                        if (tx_bits == 4'h1) begin
                            tx_state <= SPU_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous receiver, independent of the transmitter
    wire       rx_fall   = pin_prev && !pin_sync;
    wire       rx_begin  = rx_state == SPU_RX_IDLE && rx_fall && rx_en
                           && mode != SPU_MODE_SHIFT;
    wire       rx_sample = rx_state == SPU_RX_BUSY &&
                           rx_cnt >= ((rx_idx == 4'h0) ? rx_half : rx_period - 16'h0001);
    wire [3:0] rx_len    = nine_bit ? SPU_LEN_9BIT : SPU_LEN_8BIT;
    wire       rx_false  = rx_sample && rx_idx == 4'h0 && pin_sync;
    wire       rx_end    = rx_sample && rx_idx == rx_len - 4'h1;
    wire       rx_ninth  = rx_shift[8];
    // Data frames (ninth bit 0) are dropped in the nine-bit modes while multiprocessor filtering is on
    wire       rx_accept = rx_end && !(nine_bit && mp_en && !rx_ninth);
    wire       rx_set    = rx_accept || m0_done;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rx_state <= SPU_RX_IDLE;
            rx_cnt   <= 16'h0000;
            rx_idx   <= 4'h0;
            rx_shift <= 9'h000;
        end else begin
            unique case (rx_state)
                SPU_RX_IDLE: begin
                    rx_cnt <= 16'h0000;
                    rx_idx <= 4'h0;
                    if (rx_begin) begin
                        rx_state <= SPU_RX_BUSY;
                    end
                end
                SPU_RX_BUSY: begin
                    rx_cnt <= rx_sample ? 16'h0000 : rx_cnt + 16'h0001;
                    if (rx_sample) begin
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx != 4'h0 && rx_idx != rx_len - 4'h1) begin
                            rx_shift[rx_idx - 4'h1] <= pin_sync;
                        end
                    end
                    if (rx_false || rx_end) begin
                        rx_state <= SPU_RX_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holding register, loaded when a frame is accepted, freeing the shifter for the next frame
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rx_buffer <= SPU_DATA_RST;
        end else if (rx_accept) begin
            rx_buffer <= rx_shift[7:0];
        end else if (m0_done) begin
            rx_buffer <= m0_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Config and aux registers; hardware sets win over software clears
    wire [7:0] cfg_sw   = wr_cfg ? w_data : config_q;
    wire       rx_nin_n = rx_accept && nine_bit ? rx_ninth :
                          cfg_sw[SPU_B_RX_NINTH];
    wire [7:0] next_cfg = {cfg_sw[7:3], rx_nin_n,
                           cfg_sw[SPU_B_TX_FLAG] | tx_done,
                           cfg_sw[SPU_B_RX_FLAG] | rx_set};
    wire       rx_edge  = pin_prev != pin_sync;
    wire       do_wake  = rx_en && aux_q[SPU_B_REDUCED] && rx_edge;
    wire [7:0] aux_sw   = wr_aux ? {2'b00, w_data[5:0]} : aux_q;
    wire [7:0] next_aux = do_wake ? (aux_sw & ~(8'h01 << SPU_B_REDUCED)) : aux_sw;

    assign serial_irq_out         = aux_q[SPU_B_IRQ_EN] && (transmit_complete_flag || receive_complete_flag);
    assign irq_priority_out       = aux_q[SPU_B_IRQ_PRI];
    assign reduced_speed_mode_out = aux_q[SPU_B_REDUCED];

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            config_q <= SPU_CONFIG_RST;
            aux_q    <= SPU_AUX_RST;
            wake_out <= 1'b0;
        end else begin
            config_q <= next_cfg;
            aux_q    <= next_aux;
            wake_out <= do_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and timer period measurement
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            pin_meta <= serial_in_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            t1_cnt    <= 16'h0001;
            t2_cnt    <= 16'h0001;
            t1_period <= 16'hFFFF;
            t2_period <= 16'hFFFF;
        end else begin
            t1_cnt <= timer1_ovf_in ? 16'h0001 :
                      (t1_cnt == 16'hFFFF ? t1_cnt : t1_cnt + 16'h0001);
            t2_cnt <= timer2_ovf_in ? 16'h0001 :
                      (t2_cnt == 16'hFFFF ? t2_cnt : t2_cnt + 16'h0001);
            if (timer1_ovf_in) begin
                t1_period <= t1_cnt;
            end
            if (timer2_ovf_in) begin
                t2_period <= t2_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite channel handling
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            aw_held          <= 1'b0;
            aw_addr          <= '0;
            w_held           <= 1'b0;
            w_data           <= 8'h00;
            w_en             <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= SPU_RESP_OKAY;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= SPU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_in && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in[7:0];
                w_en   <= s_axi_wstrb_in[0];
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_mapped ? SPU_RESP_OKAY : SPU_RESP_SLV;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= {24'h00_0000, rd_byte};
                s_axi_rresp_out  <= rd_mapped ? SPU_RESP_OKAY : SPU_RESP_SLV;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end
endmodule : spu_serial_port

// file: spu_serial_port_asserts.sv
// Port-level checks of the four-mode serial port
`timescale 1ns/1ps
module spu_serial_port_asserts (
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        srst_in,
    // Register bus
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rready_in,
    // Serial and system
    input wire logic        serial_out_pin_out,
    input wire logic        serial_in_pin_out,
    input wire logic        serial_in_pin_oe_out,
    input wire logic        reduced_speed_mode_out,
    input wire logic        wake_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    sequence wr_both_s;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            && !s_axi_bvalid_out;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    // Shift clock low for six cycles, then back high
    sequence sclk_low_s;
        !serial_out_pin_out [*6] ##1 serial_out_pin_out;
    endsequence
    reset_idle_a: assert property ($fell(srst_in) |-> serial_out_pin_out
        && !serial_in_pin_oe_out && !s_axi_bvalid_out && !s_axi_rvalid_out)
        else $error("outputs not idle after reset");
    write_answer_a: assert property (wr_both_s |-> ##2 s_axi_bvalid_out)
        else $error("write response late");
    read_answer_a: assert property (rd_take_s |=> s_axi_rvalid_out
        && s_axi_rdata_out[31:8] == 24'h00_0000) else $error("read answer wrong");
    read_release_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("read valid not released");
    wake_pulse_a: assert property (wake_out |=> !wake_out && !reduced_speed_mode_out)
        else $error("wake pulse wrong");
    wake_cause_a: assert property (wake_out |-> $past(reduced_speed_mode_out))
        else $error("wake without reduced speed");
    shift_data_a: assert property (serial_in_pin_oe_out && $fell(serial_out_pin_out)
        |-> $stable(serial_in_pin_out)) else $error("shift data moved at clock fall");
    shift_rate_a: assert property (serial_in_pin_oe_out && $fell(serial_out_pin_out)
        |-> sclk_low_s) else $error("shift clock low phase wrong");
    start_bit_a: assert property (!serial_in_pin_oe_out && $fell(serial_out_pin_out)
        |-> !serial_out_pin_out [*6]) else $error("async bit too short");
endmodule : spu_serial_port_asserts

bind spu_serial_port spu_serial_port_asserts spu_serial_port_asserts_inst (.*);

// file: spu_serial_node.sv
// Far serial node: async frame sender and sampler
`timescale 1ns/1ps
module spu_serial_node (
    // Clock
    input  wire logic core_clk_in,
    // Link
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    // Start 0, bits LSB first, stop 1, idle high
    task automatic send(input logic [8:0] d, input int nb, input int p);
        line_out <= 1'b0;
        repeat (p) @(posedge core_clk_in);
        for (int i = 0; i < nb; i++) begin
            line_out <= d[i];
            repeat (p) @(posedge core_clk_in);
        end
        line_out <= 1'b1;
        repeat (p) @(posedge core_clk_in);
    endtask : send
    task automatic recv(output logic [8:0] d, input int nb, input int p);
        d = '0;
        @(negedge line_in);
        repeat (p / 2) @(posedge core_clk_in);
        for (int i = 0; i < nb; i++) begin
            repeat (p) @(posedge core_clk_in);
            d[i] = line_in;
        end
    endtask : recv
endmodule : spu_serial_node

// file: tb_spu_serial_port.sv
// Self-checking bench of the four-mode serial port
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_spu_serial_port;
    import spu_pkg::*;
    typedef struct {logic [7:0] cfg, aux, tx; logic [8:0] rx; int nb, p;} spu_row_t;
    logic core_clk_in, srst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in;
    logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = 4'hF;
    logic s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, timer1_ovf_in, timer2_ovf_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic serial_out_pin_out, serial_in_pin_in, serial_in_pin_out, serial_in_pin_oe_out;
    logic serial_irq_out, irq_priority_out, reduced_speed_mode_out, wake_out, node_line;
    int miscompares, checks_done, wakes, t1, t2;
    spu_row_t rows [5] = '{'{8'h98, 8'h00, 8'hA5, 9'h13C, 9, 64},
        '{8'h90, 8'h01, 8'h01, 9'h080, 9, 32}, '{8'h50, 8'h01, 8'h6B, 9'h0D2, 8, 20},
        '{8'h50, 8'h00, 8'h80, 9'h001, 8, 40}, '{8'hD8, 8'h06, 8'h5A, 9'h1FF, 9, 24}};
    spu_serial_port #(.ADDR_W(12)) spu_serial_port_inst (.*);
    spu_serial_node spu_serial_node_inst (.core_clk_in, .line_in(serial_out_pin_out),
        .line_out(node_line));
    // Data pin driven by the port while its output enable is set, else by the node
    assign serial_in_pin_in = serial_in_pin_oe_out ? serial_in_pin_out : node_line;
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        t1 <= (t1 == 19) ? 0 : t1 + 1;
        t2 <= (t2 == 23) ? 0 : t2 + 1;
        timer1_ovf_in <= (t1 == 19);
        timer2_ovf_in <= (t2 == 23);
        if (wake_out === 1'b1) wakes++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [9:0] idx, input logic [7:0] dat, output logic [1:0] resp);
        s_axi_awaddr_in  <= {idx, 2'b00};
        s_axi_wdata_in   <= {24'h00_0000, dat};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        resp = s_axi_bresp_out;
    endtask : wr
    task automatic rd(input logic [9:0] idx, output logic [31:0] dat, output logic [1:0] resp);
        s_axi_araddr_in  <= {idx, 2'b00};
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        dat = s_axi_rdata_out;
        resp = s_axi_rresp_out;
    endtask : rd
    task automatic end_sim;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge core_clk_in);
        miscompares++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        spu_row_t r;
        logic [31:0] d;
        logic [8:0] got;
        logic [7:0] b;
        logic [1:0] rs;
        {srst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 4'h8;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            wr(SPU_IDX_AUX, r.aux, rs);
            wr(SPU_IDX_CONFIG, r.cfg, rs);
            fork
                spu_serial_node_inst.recv(got, r.nb, r.p);
                spu_serial_node_inst.send(r.rx, r.nb, r.p);
                wr(SPU_IDX_DATA, r.tx, rs);
            join
            repeat (2 * r.p) @(posedge core_clk_in);
            `CHK(got, {r.nb == 9 && r.cfg[3], r.tx})
            rd(SPU_IDX_CONFIG, d, rs);
            `CHK(d[7:0], (r.nb == 9) ? {r.cfg[7:3], r.rx[8], 2'b11} : {r.cfg[7:2], 2'b11})
            rd(SPU_IDX_DATA, d, rs);
            `CHK({rs, d}, {2'b00, 24'h00_0000, r.rx[7:0]})
        end
        // Data frames dropped while multiprocessor filter is on
        wr(SPU_IDX_AUX, 8'h00, rs);
        wr(SPU_IDX_CONFIG, 8'hB0, rs);
        spu_serial_node_inst.send(9'h055, 9, 64);
        rd(SPU_IDX_CONFIG, d, rs);
        `CHK(d[7:0], 8'hB0)
        spu_serial_node_inst.send(9'h1AA, 9, 64);
        rd(SPU_IDX_CONFIG, d, rs);
        `CHK(d[7:0], 8'hB5)
        `CHK(serial_irq_out, 1'b0)
        wr(SPU_IDX_AUX, 8'h18, rs);
        `CHK(serial_irq_out, 1'b1)
        `CHK(irq_priority_out, 1'b1)
        wr(SPU_IDX_CONFIG, 8'h90, rs);
        `CHK(serial_irq_out, 1'b0)
        // Wake from reduced speed, then with receiver disabled
        wr(SPU_IDX_AUX, 8'h20, rs);
        `CHK(reduced_speed_mode_out, 1'b1)
        spu_serial_node_inst.send(9'h055, 9, 64);
        `CHK({reduced_speed_mode_out, wakes}, {1'b0, 32'd1})
        rd(SPU_IDX_CONFIG, d, rs);
        `CHK(d[7:0], 8'h91)
        rd(SPU_IDX_DATA, d, rs);
        `CHK(d[7:0], 8'h55)
        wr(SPU_IDX_CONFIG, 8'hA0, rs);
        wr(SPU_IDX_AUX, 8'h20, rs);
        spu_serial_node_inst.send(9'h1FF, 9, 64);
        `CHK({reduced_speed_mode_out, wakes}, {1'b1, 32'd1})
        // Shift-register receive from an idle data line
        wr(SPU_IDX_CONFIG, 8'h10, rs);
        repeat (100) @(posedge core_clk_in);
        rd(SPU_IDX_CONFIG, d, rs);
        `CHK(d[7:0], 8'h11)
        rd(SPU_IDX_DATA, d, rs);
        `CHK(d[7:0], 8'hFF)
        // Shift-register transmit, sampled at clock falls
        wr(SPU_IDX_CONFIG, 8'h00, rs);
        wr(SPU_IDX_DATA, 8'hC3, rs);
        for (int i = 0; i < 8; i++) begin
            @(negedge serial_out_pin_out);
            b[i] = serial_in_pin_out;
        end
        `CHK(b, 8'hC3)
        repeat (30) @(posedge core_clk_in);
        rd(SPU_IDX_CONFIG, d, rs);
        `CHK(d[7:0], 8'h02)
        rd(10'h100, d, rs);
        `CHK({rs, d}, {2'b10, 32'h0000_0000})
        wr(10'h100, 8'h11, rs);
        `CHK(rs, 2'b10)
        // Second reset restores register values
        srst_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        for (int i = 0; i < 3; i++) begin
            rd(SPU_IDX_CONFIG + 10'(i), d, rs);
            `CHK({rs, d}, {2'b00, 32'h0000_0000})
        end
        end_sim();
    end
endmodule : tb_spu_serial_port
